// ### lst_pkg.sv
// Shared constants and types for the link self-test checker.
// Assumes a single 125 MHz clock domain and a classic Wishbone register bus.

package lst_pkg;

   // -------------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // -------------------------------------------------------------------
   localparam logic [5:0] IDX_CTRL = 6'h20;
   localparam logic [5:0] IDX_STATUS = 6'h21;
   localparam logic [5:0] IDX_IRQ_STATUS = 6'h22;
   localparam logic [5:0] IDX_IRQ_MASK = 6'h23;
   localparam logic [5:0] IDX_FWD_ERR_COUNT = 6'h25;

   // -------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_OSC_BIT = 1;
   localparam int STAT_ANY_ERR_BIT = 0;
   localparam int STAT_PASS_BIT = 1;
   localparam int STAT_LOCK_BIT = 2;
   localparam int STAT_CHECK_BIT = 3;
   localparam int STAT_HOLD_BIT = 4;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_ERR_BIT = 1;
   localparam int IRQ_LOCK_BIT = 2;

   // -------------------------------------------------------------------
   // Widths and reset values
   // -------------------------------------------------------------------
   localparam int PAYLOAD_W = 35;
   localparam int ERRCNT_W = 8;
   localparam int IRQ_W = 3;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [ERRCNT_W-1:0] ERRCNT_RST = 8'h00;
   localparam logic [ERRCNT_W-1:0] ERRCNT_MAX = 8'hff;
   localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

   // -------------------------------------------------------------------
   // Timing: the remote oscillator rate and the error pulse length
   // -------------------------------------------------------------------
   localparam int OSC_FREQ_MHZ = 33;
   localparam int PASS_LOW_CYC = 1;

   // -------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT_LOCK, ST_CHECK, ST_HOLD} lst_state_t;

   typedef struct packed {
      logic valid;
      logic [PAYLOAD_W-1:0] payload;
   } lst_sym_t;

endpackage

// ### lst_checker.sv
// Receive-side self-test checker: starts a test, watches the recovered
// payload for non-zero bits and reports the result on a pass output.
// Assumes recovered symbols, lock and frame start come from mclk logic;
// the enable, clock-select, clock-present and power-down pins are async.

`timescale 1ns/1ns

module lst_checker (
   // Clock and reset.
   input wire logic mclk,
   input wire logic sys_rst,
   // Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Asynchronous pins.
   input wire logic self_test_enable_pin,
   input wire logic test_clock_source_select,
   input wire logic pclk_present,
   input wire logic power_down,
   // Recovered link side, same clock.
   input wire lst_pkg::lst_sym_t rx_sym,
   input wire logic rx_frame_start,
   input wire logic rx_lock,
   input wire logic remote_in_test,
   // Results and back channel.
   output logic pass_out,
   output logic lock_out,
   output logic bc_test_req,
   output logic bc_wake,
   output logic use_internal_oscillator,
   output logic link_normal,
   output logic irq
);

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic en_pin_s, osc_pin_s, pclk_s, pd_s;
   logic [1:0] ctrl_q;
   logic en_any, en_prev_q, en_rise;
   lst_pkg::lst_state_t state_q;
   logic pass_q, any_err_q, frame_err_q, sym_err, check_now;
   logic [lst_pkg::ERRCNT_W-1:0] errcnt_q;
   logic [lst_pkg::IRQ_W-1:0] irq_st_q;
   logic [lst_pkg::IRQ_W-1:0] irq_mask_q;
   logic [lst_pkg::IRQ_W-1:0] irq_ev;
   logic bc_req_q, bc_wake_q, osc_q, lock_q, irq_q, ack_q;
   logic [31:0] rdat_q;
   logic wb_req;
   logic wr_lane0;
   logic [5:0] idx;
   logic [31:0] rdat_d;

   // ------------------------------------------------------------------
   // Pin synchronizers
   // ------------------------------------------------------------------
   // Two flops per pin; only the second stage is ever read by logic.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
      end else begin
         sync1_q <= {power_down, pclk_present, test_clock_source_select,
                     self_test_enable_pin};
         sync2_q <= sync1_q;
      end
   end

   assign en_pin_s = sync2_q[0];
   assign osc_pin_s = sync2_q[1];
   assign pclk_s = sync2_q[2];
   assign pd_s = sync2_q[3];

   // Either source enables the test; the start is taken on the rising edge.
   assign en_any = en_pin_s | ctrl_q[lst_pkg::CTRL_EN_BIT];
   assign en_rise = en_any & ~en_prev_q;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         en_prev_q <= 1'b0;
      end else begin
         en_prev_q <= en_any;
      end
   end

   // ------------------------------------------------------------------
   // Payload comparison
   // ------------------------------------------------------------------
   // Checks only while locked so a lock drop does not flood the counter.
   assign sym_err = rx_sym.valid & (rx_sym.payload != '0);
   assign check_now = (state_q == lst_pkg::ST_CHECK) & rx_lock & en_any & ~pd_s;

   // ------------------------------------------------------------------
   // Test sequencer
   // ------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_q <= lst_pkg::ST_IDLE;
      end else if (pd_s) begin
         state_q <= lst_pkg::ST_IDLE;
      end else begin
         case (state_q)
            lst_pkg::ST_IDLE, lst_pkg::ST_HOLD: begin
               if (en_rise) begin
                  state_q <= lst_pkg::ST_WAIT_LOCK;
               end
            end
            lst_pkg::ST_WAIT_LOCK: begin
               if (!en_any) begin
                  state_q <= lst_pkg::ST_HOLD;
               end else if (rx_lock && remote_in_test) begin
                  state_q <= lst_pkg::ST_CHECK;
               end
            end
            lst_pkg::ST_CHECK: begin
               if (!en_any) begin
                  state_q <= lst_pkg::ST_HOLD;
               end
            end
            default: begin
               state_q <= lst_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Pass output
   // ------------------------------------------------------------------
   // A one-cycle low pulse stands in for the half pixel period; at
   // 125 MHz it is never longer than half of any supported pixel clock.
   always_ff @(posedge mclk) begin
      if (sys_rst || pd_s) begin
         pass_q <= 1'b1;
      end else begin
         case (state_q)
            lst_pkg::ST_IDLE: begin
               pass_q <= en_rise ? 1'b0 : 1'b1;
            end
            lst_pkg::ST_WAIT_LOCK: begin
               pass_q <= en_any && rx_lock && remote_in_test;
            end
            lst_pkg::ST_CHECK: begin
               if (!en_any) begin
                  pass_q <= ~any_err_q;
               end else begin
                  pass_q <= ~(check_now & sym_err & (~frame_err_q | rx_frame_start));
               end
            end
            lst_pkg::ST_HOLD: begin
               pass_q <= en_rise ? 1'b0 : ~any_err_q;
            end
            default: begin
               pass_q <= 1'b1;
            end
         endcase
      end
   end

   // Per-frame and per-test error memory, cleared when a new test starts.
   always_ff @(posedge mclk) begin
      if (sys_rst || pd_s || en_rise) begin
         any_err_q <= 1'b0;
         frame_err_q <= 1'b0;
      end else if (check_now) begin
         any_err_q <= any_err_q | sym_err;
         frame_err_q <= sym_err | (frame_err_q & ~rx_frame_start);
      end
   end

   // Forward error counter, saturating so a long test cannot wrap to zero.
   always_ff @(posedge mclk) begin
      if (sys_rst || en_rise) begin
         errcnt_q <= lst_pkg::ERRCNT_RST;
      end else if (check_now && sym_err && errcnt_q != lst_pkg::ERRCNT_MAX) begin
         errcnt_q <= errcnt_q + 8'h01;
      end
   end

   // ------------------------------------------------------------------
   // Back channel, clock choice and lock reporting
   // ------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (sys_rst || pd_s) begin
         bc_req_q <= 1'b0;
         bc_wake_q <= 1'b0;
      end else begin
         bc_req_q <= en_any;
         bc_wake_q <= en_any & ~(state_q == lst_pkg::ST_CHECK);
      end
   end

   // The oscillator is only chosen while no pixel clock is seen.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         osc_q <= 1'b0;
         lock_q <= 1'b0;
      end else begin
         osc_q <= (osc_pin_s | ctrl_q[lst_pkg::CTRL_OSC_BIT]) & ~pclk_s;
         lock_q <= rx_lock;
      end
   end

   // ------------------------------------------------------------------
   // Interrupts
   // ------------------------------------------------------------------
   assign irq_ev[lst_pkg::IRQ_DONE_BIT] = (state_q == lst_pkg::ST_CHECK) & ~en_any;
   assign irq_ev[lst_pkg::IRQ_ERR_BIT] = check_now & sym_err;
   assign irq_ev[lst_pkg::IRQ_LOCK_BIT] = rx_lock & ~lock_q;

   // Write one to clear; a new event in the same cycle wins over the clear.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         irq_st_q <= lst_pkg::IRQ_RST;
      end else if (ack_q == 1'b1 && wb_req && wb_we_i && wr_lane0
                   && idx == lst_pkg::IDX_IRQ_STATUS) begin
         irq_st_q <= (irq_st_q & ~wb_dat_i[lst_pkg::IRQ_W-1:0]) | irq_ev;
      end else begin
         irq_st_q <= irq_st_q | irq_ev;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(irq_st_q & irq_mask_q);
      end
   end

   // ------------------------------------------------------------------
   // Wishbone slave
   // ------------------------------------------------------------------
   assign wb_req = wb_cyc_i & wb_stb_i;
   assign wr_lane0 = wb_sel_i[0];
   assign idx = wb_adr_i[7:2];

   // Control and mask registers, written on the acknowledged cycle.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ctrl_q <= lst_pkg::CTRL_RST;
         irq_mask_q <= lst_pkg::IRQ_RST;
      end else if (ack_q && wb_req && wb_we_i && wr_lane0) begin
         if (idx == lst_pkg::IDX_CTRL) begin
            ctrl_q <= wb_dat_i[1:0];
         end
         if (idx == lst_pkg::IDX_IRQ_MASK) begin
            irq_mask_q <= wb_dat_i[lst_pkg::IRQ_W-1:0];
         end
      end
   end

   // Read mux; unmapped indices read as zero.
   always_comb begin
      rdat_d = 32'h0000_0000;
      case (idx)
         lst_pkg::IDX_CTRL: rdat_d[1:0] = ctrl_q;
         lst_pkg::IDX_STATUS: begin
            rdat_d[lst_pkg::STAT_ANY_ERR_BIT] = any_err_q;
            rdat_d[lst_pkg::STAT_PASS_BIT] = pass_q;
            rdat_d[lst_pkg::STAT_LOCK_BIT] = lock_q;
            rdat_d[lst_pkg::STAT_CHECK_BIT] = (state_q == lst_pkg::ST_CHECK);
            rdat_d[lst_pkg::STAT_HOLD_BIT] = (state_q == lst_pkg::ST_HOLD);
         end
         lst_pkg::IDX_IRQ_STATUS: rdat_d[lst_pkg::IRQ_W-1:0] = irq_st_q;
         lst_pkg::IDX_IRQ_MASK: rdat_d[lst_pkg::IRQ_W-1:0] = irq_mask_q;
         lst_pkg::IDX_FWD_ERR_COUNT: rdat_d[lst_pkg::ERRCNT_W-1:0] = errcnt_q;
         default: rdat_d = 32'h0000_0000;
      endcase
   end

   // One wait state: ack rises the cycle after the request and drops next.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q <= wb_req & ~ack_q;
         rdat_q <= rdat_d;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign pass_out = pass_q;
   assign lock_out = lock_q;
   assign bc_test_req = bc_req_q;
   assign bc_wake = bc_wake_q;
   assign use_internal_oscillator = osc_q;
   assign link_normal = ~bc_req_q;
   assign irq = irq_q;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   a_start_request: assert property (@(posedge mclk) disable iff (sys_rst)
      (en_rise && !pd_s) |=> bc_req_q && state_q == lst_pkg::ST_WAIT_LOCK)
      else $error("Test start did not raise the back channel request.");
   a_wake_remote: assert property (@(posedge mclk) disable iff (sys_rst)
      $rose(bc_req_q) |-> bc_wake_q)
      else $error("Remote wake missing when the request rose.");
   a_lock_start: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_q == lst_pkg::ST_WAIT_LOCK && en_any && !pd_s && rx_lock && remote_in_test)
      |=> state_q == lst_pkg::ST_CHECK && pass_q)
      else $error("Checking did not start with pass high after lock.");
   a_error_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
      (check_now && sym_err && !frame_err_q) |=> !pass_q && any_err_q)
      else $error("First frame error did not pulse pass low.");
   a_one_per_frame: assert property (@(posedge mclk) disable iff (sys_rst)
      (check_now && sym_err && frame_err_q && !rx_frame_start) |=> pass_q)
      else $error("Second error in one frame pulsed pass again.");
   a_count_step: assert property (@(posedge mclk) disable iff (sys_rst)
      (check_now && sym_err && errcnt_q < 8'h10) |=> errcnt_q == $past(errcnt_q) + 8'h01)
      else $error("Error counter did not step on a payload error.");
   a_stop_hold: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_q == lst_pkg::ST_CHECK && !en_any && !pd_s)
      |=> state_q == lst_pkg::ST_HOLD ##1 (pass_q == !any_err_q) && link_normal)
      else $error("Stop did not hold the result and return the link.");
   a_hold_steady: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_q == lst_pkg::ST_HOLD && !en_rise && !pd_s) [*2] |-> pass_q == !any_err_q)
      else $error("Held result changed without a new test.");
   a_osc_gate: assert property (@(posedge mclk) disable iff (sys_rst)
      pclk_s |=> !use_internal_oscillator)
      else $error("Oscillator chosen while pixel clock present.");
   a_lock_valid: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_q == lst_pkg::ST_CHECK && rx_lock) |=> lock_out)
      else $error("Lock output dropped during a locked test.");

endmodule // lst_checker

// ### lst_remote_model.sv
// Remote serializer model: wakes on the back channel, joins the test and
// sends framed all-zero symbols. Assumes it shares mclk with the checker.
`timescale 1ns/1ns
module lst_remote_model #(
   parameter int DLY = 3,
   parameter int FRAME = 8
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic sys_rst,
   // Back channel from the checker.
   input wire logic bc_test_req,
   input wire logic bc_wake,
   // Error steering from the bench.
   input wire logic inject,
   input wire logic [34:0] err_pat,
   input wire logic bc_crc_bad,
   // Back-channel CRC error count kept by the far end.
   output logic [7:0] bc_crc_errs,
   // Forward link toward the checker.
   output lst_pkg::lst_sym_t rx_sym,
   output logic rx_frame_start,
   output logic rx_lock,
   output logic remote_in_test
);
   logic awake_q;
   logic [7:0] dly_q;
   logic [7:0] pos_q;
   logic [34:0] idle_q;
   logic sym_ok;
   logic in_test_q;
   // A sleeping serializer cannot join, so the wake request must land first.
   always_ff @(posedge mclk) begin
      if (sys_rst) awake_q <= 1'b0;
      else if (bc_wake) awake_q <= 1'b1;
   end
   // DLY sets how slowly the far end joins; zero answers at once.
   always_ff @(posedge mclk) begin
      if (sys_rst || !bc_test_req || !awake_q) dly_q <= 8'h00;
      else if (dly_q < DLY) dly_q <= dly_q + 8'h01;
   end
   assign remote_in_test = bc_test_req && awake_q && (dly_q == DLY[7:0]);
   // Lock stays once gained; the link itself is never dropped here.
   always_ff @(posedge mclk) begin
      if (sys_rst) rx_lock <= 1'b0;
      else if (remote_in_test) rx_lock <= 1'b1;
   end
   // Frame position and an idle pattern that changes every cycle.
   always_ff @(posedge mclk) begin
      if (!remote_in_test || pos_q == FRAME - 1) pos_q <= 8'h00;
      else pos_q <= pos_q + 8'h01;
      idle_q <= sys_rst ? 35'h2aaaaaaaa : ~idle_q;
   end
   assign sym_ok = remote_in_test && rx_lock;
   assign rx_frame_start = sym_ok && (pos_q == 8'h00);
   assign rx_sym = {sym_ok, sym_ok ? (inject ? err_pat : 35'h0) : idle_q};
   // Entry to test clears the CRC count; it counts only in test, once the back
   // channel is up, and keeps the last run's value after the test ends.
   always_ff @(posedge mclk) begin
      if (sys_rst) in_test_q <= 1'b0;
      else in_test_q <= remote_in_test;
   end
   always_ff @(posedge mclk) begin
      if (sys_rst || (remote_in_test && !in_test_q)) bc_crc_errs <= 8'h00;
      else if (remote_in_test && awake_q && bc_crc_bad && bc_crc_errs != 8'hff)
         bc_crc_errs <= bc_crc_errs + 8'h01;
   end
endmodule // lst_remote_model

// ### tb_lst_checker.sv
// Self-checking bench for the link self-test checker.
// Assumes the package, checker and remote model are compiled first.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin errors++; \
   $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
`define WAITV(s, v) begin wn = 0; #1; while ((s) !== (v) && wn < 300) begin \
   @(posedge mclk); #1; wn++; end end
module tb_lst_checker;
   logic mclk, sys_rst, wb_cyc, wb_stb, wb_we, wb_ack, pin, sel_pin, pclk_ok, pdn;
   logic fs, lock, rin, pass, lock_o, req, wake, osc, norm, irq, inject, pass_q, cnt_en;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_wdat, wb_rdat, lfsr, exp_v;
   logic [34:0] err_pat;
   logic [3:0] strap_pins;
   logic bc_crc_bad;
   logic [7:0] crc_errs;
   lst_pkg::lst_sym_t rx_sym;
   int errors, check_count, falls, wn;
   logic [31:0] exp_q[$];

   lst_checker lst_checker_i (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
      .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
      .self_test_enable_pin(pin), .test_clock_source_select(sel_pin),
      .pclk_present(pclk_ok), .power_down(pdn), .rx_sym(rx_sym), .rx_frame_start(fs),
      .rx_lock(lock), .remote_in_test(rin), .pass_out(pass), .lock_out(lock_o),
      .bc_test_req(req), .bc_wake(wake), .use_internal_oscillator(osc),
      .link_normal(norm), .irq(irq));
   lst_remote_model #(.DLY(3), .FRAME(8)) lst_remote_model_i (.mclk(mclk),
      .sys_rst(sys_rst), .bc_test_req(req), .bc_wake(wake), .inject(inject),
      .err_pat(err_pat), .bc_crc_bad(bc_crc_bad), .bc_crc_errs(crc_errs),
      .rx_sym(rx_sym), .rx_frame_start(fs), .rx_lock(lock),
      .remote_in_test(rin));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   function automatic logic [31:0] step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // One classic cycle; the request is held until ack is seen at an edge.
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      @(posedge mclk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_wdat <= dat;
      wb_sel <= 4'hf;
      do begin
         @(posedge mclk);
      end while (wb_ack !== 1'b1);
      `CHK("wb_ack", 1'b1, wb_ack)
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] adr, input logic [31:0] ex);
      exp_q.push_back(ex);
      wb(1'b0, adr, 32'h0);
   endtask

   task automatic results;
      if (errors == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // Read answers meet the oldest note; pass pulses are counted when armed.
   always @(posedge mclk) begin
      pass_q <= pass;
      if (cnt_en && pass_q === 1'b1 && pass === 1'b0) falls++;
      if (wb_ack === 1'b1 && wb_we === 1'b0) begin
         exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hdeadbeef;
         `CHK("read_data", exp_v, wb_rdat)
      end
   end

   initial begin
      #400000;
      errors++;
      results;
   end

   initial begin
      {sys_rst, pclk_ok} = 2'b11;
      {wb_cyc, wb_stb, wb_we, pin, sel_pin, pdn, inject, cnt_en} = 8'h0;
      {wb_adr, wb_sel, wb_wdat, err_pat, strap_pins, bc_crc_bad} = '0;
      lfsr = 32'h15d1;
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      rd(8'h80, 32'h0);
      rd(8'h84, 32'h2);
      rd(8'h94, 32'h0);
      wb(1'b1, 8'h00, 32'hff);
      rd(8'h00, 32'h0);
      // Oscillator choice by pin, then by register, with no pixel clock.
      @(posedge mclk);
      pclk_ok <= 1'b0;
      sel_pin <= 1'b1;
      `WAITV(osc, 1'b1)
      `CHK("osc_pin", 1'b1, osc)
      @(posedge mclk);
      sel_pin <= 1'b0;
      `WAITV(osc, 1'b0)
      `CHK("osc_off", 1'b0, osc)
      wb(1'b1, 8'h80, 32'h2);
      `WAITV(osc, 1'b1)
      `CHK("osc_reg", 1'b1, osc)
      rd(8'h80, 32'h2);
      wb(1'b1, 8'h80, 32'h0);
      pclk_ok <= 1'b1;
      strap_pins <= 4'h1;
      // Clean run from the pin, started only with the straps in place; the
      // test lasts as long as the pin is held.
      @(posedge mclk);
      pin <= strap_pins[0] & ~|strap_pins[3:1];
      @(posedge mclk);
      #1 `CHK("req_sync", 1'b0, req)
      `WAITV(req, 1'b1)
      `CHK("bc_req", 1'b1, req)
      `CHK("bc_wake", 1'b1, wake)
      `CHK("pass_wait", 1'b0, pass)
      `WAITV(pass, 1'b1)
      `CHK("pass_chk", 1'b1, pass)
      // Back-channel CRC faults during the run are seen by the far end only.
      @(posedge mclk);
      bc_crc_bad <= 1'b1;
      repeat (20) @(posedge mclk);
      bc_crc_bad <= 1'b0;
      #1 `CHK("lock_out", lock, lock_o)
      `CHK("pass_clean", 1'b1, pass)
      @(posedge mclk);
      pin <= 1'b0;
      `WAITV(norm, 1'b1)
      `CHK("link_norm", 1'b1, norm)
      `CHK("pass_held", 1'b1, pass)
      `CHK("irq_masked", 1'b0, irq)
      `CHK("crc_clean", 8'h14, crc_errs)
      rd(8'h84, 32'h16);
      rd(8'h88, 32'h5);
      wb(1'b1, 8'h88, 32'h7);
      rd(8'h88, 32'h0);
      // Errored run from the register: three frames, two bad symbols each.
      wb(1'b1, 8'h8c, 32'h2);
      wb(1'b1, 8'h80, 32'h1);
      `WAITV(req, 1'b1)
      `CHK("reg_start", 1'b1, req)
      `WAITV(pass, 1'b1)
      falls = 0;
      cnt_en = 1'b1;
      repeat (3) begin
         `WAITV(fs, 1'b1)
         @(posedge mclk);
         inject <= 1'b1;
         bc_crc_bad <= 1'b1;
         err_pat <= {lfsr[2:0], lfsr} | 35'h1;
         lfsr = step(lfsr);
         @(posedge mclk);
         err_pat <= {lfsr[2:0], lfsr} | 35'h1;
         lfsr = step(lfsr);
         @(posedge mclk);
         inject <= 1'b0;
         bc_crc_bad <= 1'b0;
      end
      repeat (4) @(posedge mclk);
      #1 `CHK("err_pulses", 3, falls)
      cnt_en = 1'b0;
      rd(8'h94, 32'h6);
      wb(1'b1, 8'h80, 32'h0);
      `WAITV(norm, 1'b1)
      `CHK("pass_fail", 1'b0, pass)
      `CHK("crc_run", 8'h06, crc_errs)
      `CHK("irq_err", 1'b1, irq)
      rd(8'h84, 32'h15);
      wb(1'b1, 8'h88, 32'h2);
      repeat (2) @(posedge mclk);
      #1 `CHK("irq_clr", 1'b0, irq)
      repeat (5) @(posedge mclk);
      #1 `CHK("pass_keep", 1'b0, pass)
      @(posedge mclk);
      pdn <= 1'b1;
      `WAITV(pass, 1'b1)
      `CHK("pass_pdn", 1'b1, pass)
      @(posedge mclk);
      pdn <= 1'b0;
      rd(8'h94, 32'h6);
      results;
   end
endmodule // tb_lst_checker
